// ### core/dcl_regs.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_cfg.svh"

module dcl_regs (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Register port
  input  wire dcl_pkg::dcl_bus_req_t   bus_i,
  output logic [7:0]                   rdata_o,
  // Measurement engine, same clock
  input  wire logic                    conv_done_i,
  input  wire dcl_pkg::dcl_limit_ev_t  conv_i,
  input  wire logic                    comparator_mode_i,
  input  wire logic                    beta_auto_upd_i,
  input  wire logic [2:0]              beta_auto_val_i,
  input  wire logic [1:0]              ideal_ch_i,
  // Settings in use
  output dcl_pkg::dcl_beta_t           d1_beta_o,
  output logic [2:0]                   d2_beta_select_o,
  output logic [5:0]                   ideal_code_o,
  output logic                         ideal_code_valid_o,
  // Status towards the rest of the device
  output logic                         over_summary_o,
  output logic                         under_summary_o,
  output logic                         limit_event_output_o
);
  import dcl_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Threshold code to count: 000->1, 001->2, 011->3, 111->4
  function automatic logic [2:0] thr_count(input logic [2:0] code);
    thr_count = {2'b00, code[0]} + {2'b00, code[1]} + {2'b00, code[2]} + 3'd1;
  endfunction

  // Ideality address to word index, 3 when not an ideality address
  function automatic logic [1:0] ideal_idx(input logic [7:0] addr);
    if (addr == `DCL_ADR_IDEAL1) begin
      ideal_idx = 2'd0;
    end else if (addr == `DCL_ADR_IDEAL2) begin
      ideal_idx = 2'd1;
    end else if (addr == `DCL_ADR_IDEAL3) begin
      ideal_idx = 2'd2;
    end else begin
      ideal_idx = 2'd3;
    end
  endfunction

  // Status register hit, bit 0 over flags, bit 1 under flags
  function automatic logic [1:0] flag_sel(input logic [7:0] addr);
    if (addr == `DCL_ADR_OVER) begin
      flag_sel = 2'b01;
    end else if (addr == `DCL_ADR_UNDER) begin
      flag_sel = 2'b10;
    end else begin
      flag_sel = 2'b00;
    end
  endfunction

  // ---------------------------------------------------------------
  // Ideality store
  // ---------------------------------------------------------------

  dcl_mem_state_t ideal_words;
  logic [1:0]     wr_idx;
  logic           ideal_wr;

  assign wr_idx   = ideal_idx(bus_i.addr);
  assign ideal_wr = bus_i.wr && (wr_idx != 2'd3);

  // Only bits 5:0 are stored, upper bits dropped
  dcl_ideal_mem u_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_i      (ideal_wr),
    .wr_idx_i  (wr_idx),
    .wr_data_i (bus_i.wdata[5:0]),
    .words_o   (ideal_words)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  dcl_state_t s_reg;
  dcl_state_t s_next;

  logic [3:0] set_over;
  logic [3:0] set_under;
  logic [3:0] live_over;
  logic [3:0] clr_over;
  logic [3:0] clr_under;
  logic [2:0] thr;
  logic [2:0] cnt_inc;
  logic [1:0] rd_idx;
  logic [5:0] code;
  logic [1:0] stat_hit;

  // Beta and configuration writes
  always_comb begin
    s_next    = s_reg;
    set_over  = 4'h0;
    set_under = 4'h0;
    live_over = 4'h0;
    clr_over  = 4'h0;
    clr_under = 4'h0;
    thr       = thr_count(s_reg.alert_thr);
    cnt_inc   = 3'd0;
    rd_idx    = 2'd3;
    code      = 6'h00;
    stat_hit  = flag_sel(bus_i.addr);

    // Register writes; read-only and status addresses ignore writes
    if (bus_i.wr) begin
      if (bus_i.addr == `DCL_ADR_BETA1) begin
        s_next.beta1.autodetect_on = bus_i.wdata[`DCL_BETA_EN_BIT];
        if (!bus_i.wdata[`DCL_BETA_EN_BIT]) begin
          s_next.beta1.select = bus_i.wdata[2:0];
        end
      end else if (bus_i.addr == `DCL_ADR_MASK) begin
        s_next.mask = bus_i.wdata[3:0];
      end else if (bus_i.addr == `DCL_ADR_CONSEC) begin
        s_next.alert_thr = bus_i.wdata[`DCL_THR_MSB:`DCL_THR_LSB];
      end
    end

    // Hardware owns the field while autodetect stays on
    if (s_reg.beta1.autodetect_on && s_next.beta1.autodetect_on && beta_auto_upd_i) begin
      s_next.beta1.select = beta_auto_val_i;
    end

    // -------------------------------------------------------------
    // Limit events
    // -------------------------------------------------------------
    // A channel counts only while its errors come back to back; a
    // clean conversion restarts it, so one noisy sample cannot alert
    // once the threshold is above one, save an under-limit sample in comparator mode, where under is not counted.
    // Consecutive counters per channel
    if (conv_done_i) begin
      for (int i = 0; i < 4; i++) begin
        cnt_inc = s_reg.cnt[i] + 3'd1;
        if (comparator_mode_i) begin
          // Only over-limit counts; the counter holds once reached
          if (conv_i.over[i]) begin
            if (cnt_inc >= thr) begin
              s_next.cnt[i] = thr;
              live_over[i]  = 1'b1;
            end else begin
              s_next.cnt[i] = cnt_inc;
            end
          end else begin
            s_next.cnt[i] = 3'd0;
          end
        end else if (conv_i.over[i] || conv_i.under[i]) begin
          if (cnt_inc >= thr) begin
            set_over[i]   = conv_i.over[i];
            set_under[i]  = conv_i.under[i];
            s_next.cnt[i] = 3'd0;
          end else begin
            s_next.cnt[i] = cnt_inc;
          end
        end else begin
          s_next.cnt[i] = 3'd0;
        end
      end
    end

    // -------------------------------------------------------------
    // Status flags
    // -------------------------------------------------------------
    // A read wipes the whole register; over and under flags clear
    // apart, so a host polling both must read each of them.
    // Clearing reads only matter for sticky flags
    if (bus_i.rd && !comparator_mode_i) begin
      if (stat_hit[0]) begin
        clr_over = 4'hf;
      end else if (stat_hit[1]) begin
        clr_under = 4'hf;
      end
    end

    // Comparator mode tracks the live result, otherwise sticky
    if (comparator_mode_i) begin
      if (conv_done_i) begin
        s_next.over_flags  = live_over;
        s_next.under_flags = conv_i.under;
      end
    end else begin
      // Set beats clear so an event never slips past a read
      s_next.over_flags  = (s_reg.over_flags & ~clr_over) | set_over;
      s_next.under_flags = (s_reg.under_flags & ~clr_under) | set_under;
    end

    // -------------------------------------------------------------
    // Summaries and alert
    // -------------------------------------------------------------
    // Both are taken from the next flags, so they move in the same
    // cycle as the flags they describe and never lag a clearing read.
    // Summary bits follow the flags, so a read clears them too
    s_next.over_sum  = |s_next.over_flags;
    s_next.under_sum = |s_next.under_flags;

    // Masked channels keep their flags but stay off the pin
    s_next.alert = |((s_next.over_flags | s_next.under_flags) & ~s_next.mask);

    // -------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------
    // Unmapped addresses return zero, never stale data
    // Read data, shown in the cycle after the strobe
    s_next.rdata = `DCL_RD_ZERO;
    if (bus_i.rd) begin
      rd_idx = ideal_idx(bus_i.addr);
      if (bus_i.addr == `DCL_ADR_BETA1) begin
        s_next.rdata = {4'h0, s_reg.beta1};
      end else if (bus_i.addr == `DCL_ADR_BETA2) begin
        s_next.rdata = {5'h00, s_reg.beta2};
      end else if (bus_i.addr == `DCL_ADR_MASK) begin
        s_next.rdata = {4'h0, s_reg.mask};
      end else if (bus_i.addr == `DCL_ADR_CONSEC) begin
        s_next.rdata = {4'h0, s_reg.alert_thr, 1'b0};
      end else if (stat_hit[0]) begin
        s_next.rdata = {4'h0, s_reg.over_flags};
      end else if (stat_hit[1]) begin
        s_next.rdata = {4'h0, s_reg.under_flags};
      end else if (rd_idx != 2'd3) begin
        s_next.rdata = {2'b00, ideal_words.word[rd_idx]};
      end
    end

    // -------------------------------------------------------------
    // Conversion settings
    // -------------------------------------------------------------
    // Channel index 3 has no word; it yields code 00, which is then
    // flagged invalid rather than guessed
    // Ideality code handed to the conversion for the channel asked
    if (ideal_ch_i != 2'd3) begin
      code = ideal_words.word[ideal_ch_i];
    end
    s_next.ideal_code  = code;
    // Codes outside the table have no factor in either model set
    s_next.ideal_valid = (code >= `DCL_IDEAL_MIN) && (code <= `DCL_IDEAL_MAX);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  // No hysteresis in comparator mode: a channel sitting on its limit
  // may toggle its flag with every conversion.
  // Diode 2 beta is a constant flop, so no write path reaches it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg             <= '0;
      s_reg.beta1       <= `DCL_RST_BETA1;
      s_reg.beta2       <= `DCL_RST_BETA2;
      s_reg.mask        <= `DCL_RST_MASK;
      s_reg.alert_thr   <= `DCL_RST_THR;
      s_reg.over_flags  <= `DCL_RST_FLAGS;
      s_reg.under_flags <= `DCL_RST_FLAGS;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign rdata_o              = s_reg.rdata;
  assign d1_beta_o            = s_reg.beta1;
  assign d2_beta_select_o     = s_reg.beta2;
  assign ideal_code_o         = s_reg.ideal_code;
  assign ideal_code_valid_o   = s_reg.ideal_valid;
  assign over_summary_o       = s_reg.over_sum;
  assign under_summary_o      = s_reg.under_sum;
  assign limit_event_output_o = s_reg.alert;

endmodule

`default_nettype wire

// ### core/dcl_cfg.svh
`ifndef DCL_CFG_SVH
`define DCL_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define DCL_ADR_MASK    8'h1f
`define DCL_ADR_CONSEC  8'h22
`define DCL_ADR_BETA1   8'h25
`define DCL_ADR_BETA2   8'h26
`define DCL_ADR_IDEAL1  8'h27
`define DCL_ADR_IDEAL2  8'h28
`define DCL_ADR_IDEAL3  8'h31
`define DCL_ADR_OVER    8'h35
`define DCL_ADR_UNDER   8'h36

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DCL_BETA_EN_BIT 3
`define DCL_THR_LSB     1
`define DCL_THR_MSB     3

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define DCL_RST_BETA1   4'h8
`define DCL_RST_BETA2   3'h7
`define DCL_RST_IDEAL   6'h12
`define DCL_RST_MASK    4'h0
`define DCL_RST_THR     3'h0
`define DCL_RST_FLAGS   4'h0
`define DCL_BETA_OFF    3'h7
`define DCL_IDEAL_MIN   6'h08
`define DCL_IDEAL_MAX   6'h37
`define DCL_RD_ZERO     8'h00

`endif

// ### core/dcl_pkg.sv
package dcl_pkg;

  // Beta configuration of one channel
  typedef struct packed {
    logic       autodetect_on;
    logic [2:0] select;
  } dcl_beta_t;

  // Per-conversion limit result, bit 0 internal, bits 3:1 diodes 1..3
  typedef struct packed {
    logic [3:0] over;
    logic [3:0] under;
  } dcl_limit_ev_t;

  // Software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dcl_bus_req_t;

  // Ideality store contents
  typedef struct packed {
    logic [2:0][5:0] word;
  } dcl_mem_state_t;

  // Whole state of the register bank
  typedef struct packed {
    dcl_beta_t       beta1;
    logic [2:0]      beta2;
    logic [3:0]      mask;
    logic [2:0]      alert_thr;
    logic [3:0]      over_flags;
    logic [3:0]      under_flags;
    logic [3:0][2:0] cnt;
    logic [7:0]      rdata;
    logic            alert;
    logic            over_sum;
    logic            under_sum;
    logic [5:0]      ideal_code;
    logic            ideal_valid;
  } dcl_state_t;

endpackage

// ### core/dcl_ideal_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcl_cfg.svh"

module dcl_ideal_mem (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Write port
  input  wire logic                    wr_i,
  input  wire logic [1:0]              wr_idx_i,
  input  wire logic [5:0]              wr_data_i,
  // Stored words, straight from the flops
  output dcl_pkg::dcl_mem_state_t      words_o
);
  import dcl_pkg::*;

  dcl_mem_state_t s_reg;
  dcl_mem_state_t s_next;

  // Index 3 is not a word; such writes fall through untouched
  always_comb begin
    s_next = s_reg;
    if (wr_i && (wr_idx_i != 2'd3)) begin
      s_next.word[wr_idx_i] = wr_data_i;
    end
  end

  // All three channels start at the nominal setting
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= {3{`DCL_RST_IDEAL}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign words_o = s_reg;

endmodule

`default_nettype wire

// ### verification/dcl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_regs_monitor (
  // Clock, reset and bus
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire dcl_pkg::dcl_bus_req_t bus_i,
  input wire logic [7:0]            rdata_o,
  // Engine side
  input wire logic                  conv_done_i,
  input wire logic                  comparator_mode_i,
  input wire logic                  beta_auto_upd_i,
  input wire logic [2:0]            beta_auto_val_i,
  // Outputs watched
  input wire dcl_pkg::dcl_beta_t    d1_beta_o,
  input wire logic [2:0]            d2_beta_select_o,
  input wire logic [5:0]            ideal_code_o,
  input wire logic                  ideal_code_valid_o,
  input wire logic                  over_summary_o,
  input wire logic                  under_summary_o,
  input wire logic                  limit_event_output_o
);
  import dcl_pkg::*;
  // ------------------------------
  // Properties
  // ------------------------------
  logic wr_beta;
  logic rd_quiet;
  // A racing event or comparator mode may keep flags up
  assign wr_beta = bus_i.wr && bus_i.addr == 8'h25;
  assign rd_quiet = bus_i.rd && !conv_done_i && !comparator_mode_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_upper_zero: assert property (
    bus_i.rd && bus_i.addr[7:4] == 4'h2 |=> rdata_o[7:6] == 2'b00)
    else $error("upper bits set");
  chk_d2_fixed: assert property (d2_beta_select_o == 3'h7)
    else $error("d2 beta moved");
  chk_beta_en: assert property (
    wr_beta |=> d1_beta_o.autodetect_on == $past(bus_i.wdata[3]))
    else $error("beta enable not written");
  chk_beta_hold: assert property (
    !wr_beta && !beta_auto_upd_i |=> $stable(d1_beta_o))
    else $error("beta changed unasked");
  chk_auto_upd: assert property (
    d1_beta_o.autodetect_on && beta_auto_upd_i && !wr_beta
    |=> d1_beta_o.select == $past(beta_auto_val_i))
    else $error("autodetect value lost");
  chk_ideal_rng: assert property (
    ideal_code_valid_o == (ideal_code_o >= 6'h08 && ideal_code_o <= 6'h37))
    else $error("ideality range flag wrong");
  chk_over_rise: assert property (
    $rose(over_summary_o) |-> $past(conv_done_i))
    else $error("over summary without conversion");
  chk_over_clr: assert property (
    rd_quiet && bus_i.addr == 8'h35 |=> !over_summary_o)
    else $error("over summary kept");
  chk_under_clr: assert property (
    rd_quiet && bus_i.addr == 8'h36 |=> !under_summary_o)
    else $error("under summary kept");
  chk_alert_src: assert property (
    limit_event_output_o |-> over_summary_o || under_summary_o)
    else $error("alert without flag");
endmodule
bind dcl_regs dcl_regs_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .conv_done_i(conv_done_i), .comparator_mode_i(comparator_mode_i),
  .beta_auto_upd_i(beta_auto_upd_i), .beta_auto_val_i(beta_auto_val_i),
  .d1_beta_o(d1_beta_o), .d2_beta_select_o(d2_beta_select_o), .ideal_code_o(ideal_code_o),
  .ideal_code_valid_o(ideal_code_valid_o), .over_summary_o(over_summary_o),
  .under_summary_o(under_summary_o), .limit_event_output_o(limit_event_output_o));
`default_nettype wire

// ### verification/dcl_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_meas_model (
  // Clock, reset, command
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   go_i,
  input  wire dcl_pkg::dcl_limit_ev_t ev_i,
  // Result towards the bank
  output logic                        conv_done_o,
  output dcl_pkg::dcl_limit_ev_t      conv_o
);
  import dcl_pkg::*;
  // Result toggles between pulses so stale data never looks valid
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_done_o <= 1'b0;
      conv_o <= '0;
    end else begin
      conv_done_o <= go_i;
      conv_o <= go_i ? ev_i : ~conv_o;
    end
  end
endmodule
`default_nettype wire

// ### verification/dcl_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_regs_tb;
  import dcl_pkg::*;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  logic clk_i, rst_i, go, cmp, aupd, done, iv, osum, usum, alrt;
  logic [2:0] aval, b2;
  logic [1:0] ch;
  logic [5:0] ic;
  logic [7:0] rdata;
  dcl_bus_req_t bus;
  dcl_limit_ev_t ev, conv;
  dcl_beta_t b1;
  int n_fail, n_tests;
  localparam logic [7:0] RA [10] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h31, 8'h35, 8'h36,
    8'h22, 8'h1f, 8'h40};
  localparam logic [7:0] RE [10] = '{8'h08, 8'h07, 8'h12, 8'h12, 8'h12, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  dcl_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .conv_done_i(done), .conv_i(conv), .comparator_mode_i(cmp), .beta_auto_upd_i(aupd),
    .beta_auto_val_i(aval), .ideal_ch_i(ch), .d1_beta_o(b1), .d2_beta_select_o(b2),
    .ideal_code_o(ic), .ideal_code_valid_o(iv), .over_summary_o(osum),
    .under_summary_o(usum), .limit_event_output_o(alrt));
  dcl_meas_model me_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ev_i(ev),
    .conv_done_o(done), .conv_o(conv));
  // Free running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  // Read data stands one cycle only, so sample just after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic cv(input logic [3:0] o, input logic [3:0] u);
    @(posedge clk_i);
    go <= 1'b1;
    ev <= '{over: o, under: u};
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic au(input logic [2:0] v);
    @(posedge clk_i);
    aupd <= 1'b1;
    aval <= v;
    @(posedge clk_i);
    aupd <= 1'b0;
  endtask
  task automatic ich(input logic [1:0] c, input logic [5:0] e, input logic v);
    @(posedge clk_i);
    ch <= c;
    @(posedge clk_i);
    #1 chk("ideal", {2'b00, e}, {2'b00, ic});
    chk("ideal_ok", {7'h0, v}, {7'h0, iv});
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    bus = '0;
    go = 1'b0;
    ev = '0;
    cmp = 1'b0;
    aupd = 1'b0;
    aval = 3'h0;
    ch = 2'd0;
    n_fail = 0;
    n_tests = 0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (RA[i]) rd(RA[i], RE[i]);
    ich(2'd0, 6'h12, 1'b1);
    ich(2'd3, 6'h00, 1'b0);
    // Ideality codes, both range ends and a too-wide write
    wr(8'h27, 8'h15);
    wr(8'h28, 8'hff);
    wr(8'h31, 8'h08);
    rd(8'h28, 8'h3f);
    ich(2'd0, 6'h15, 1'b1);
    ich(2'd1, 6'h3f, 1'b0);
    ich(2'd2, 6'h08, 1'b1);
    wr(8'h31, 8'h37);
    ich(2'd2, 6'h37, 1'b1);
    rd(8'h31, 8'h37);
    // Beta: select ignored while autodetect is on
    wr(8'h25, 8'h0d);
    rd(8'h25, 8'h08);
    au(3'h3);
    rd(8'h25, 8'h0b);
    wr(8'h25, 8'h07);
    au(3'h2);
    rd(8'h25, 8'h07);
    chk("d1_beta", 8'h07, {4'h0, b1});
    wr(8'h26, 8'h00);
    rd(8'h26, 8'h07);
    chk("d2_beta", 8'h07, {5'h00, b2});
    // Sticky over and under flags, cleared by reading
    cv(4'h2, 4'h0);
    chk("alert", 8'h01, {7'h0, alrt});
    chk("osum", 8'h01, {7'h0, osum});
    rd(8'h35, 8'h02);
    rd(8'h35, 8'h00);
    chk("osum", 8'h00, {7'h0, osum});
    chk("alert", 8'h00, {7'h0, alrt});
    cv(4'h0, 4'h8);
    chk("usum", 8'h01, {7'h0, usum});
    rd(8'h36, 8'h08);
    chk("usum", 8'h00, {7'h0, usum});
    // Event racing a clearing read
    @(posedge clk_i);
    go <= 1'b1;
    ev <= '{over: 4'h1, under: 4'h0};
    @(posedge clk_i);
    go <= 1'b0;
    bus.addr <= 8'h35;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 chk("osum", 8'h01, {7'h0, osum});
    rd(8'h35, 8'h01);
    // Masked channel records but stays quiet
    wr(8'h1f, 8'h01);
    cv(4'h1, 4'h0);
    chk("alert", 8'h00, {7'h0, alrt});
    chk("osum", 8'h01, {7'h0, osum});
    rd(8'h35, 8'h01);
    wr(8'h1f, 8'h00);
    // Two in a row needed
    wr(8'h22, 8'h02);
    cv(4'h2, 4'h0);
    chk("osum", 8'h00, {7'h0, osum});
    cv(4'h2, 4'h0);
    chk("alert", 8'h01, {7'h0, alrt});
    rd(8'h35, 8'h02);
    wr(8'h22, 8'h00);
    // Comparator mode follows the live condition
    @(posedge clk_i);
    cmp <= 1'b1;
    cv(4'h0, 4'h4);
    rd(8'h36, 8'h04);
    chk("usum", 8'h01, {7'h0, usum});
    cv(4'h0, 4'h0);
    chk("usum", 8'h00, {7'h0, usum});
    cv(4'h4, 4'h0);
    rd(8'h35, 8'h04);
    chk("osum", 8'h01, {7'h0, osum});
    chk("alert", 8'h01, {7'h0, alrt});
    cv(4'h0, 4'h0);
    chk("osum", 8'h00, {7'h0, osum});
    // Reset again in mid-run: settings go back to their defaults
    wr(8'h22, 8'h0e);
    @(posedge clk_i);
    cmp <= 1'b0;
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h25, 8'h08);
    rd(8'h27, 8'h12);
    rd(8'h22, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
